// ### src/asf_sample_fifo.sv
`timescale 1ns/1ns
`default_nettype none
// What this block does
// RULE1: With buffer enabled, output registers show the oldest stored set, not live data.
// RULE2: Mode field 00 bypass, 01 fill-once, 10 streaming, 11 stream-to-fill-once.
// RULE3: Stream-to-fill trigger is the generator's active flag, not any pin.
// RULE4: Watermark flag is high while unread count exceeds the watermark level.
// RULE5: Status follows every sample write and every sample set read.
// RULE6: Overrun high at 32 unread; next period overwrites oldest; first read clears it.
// RULE7: Empty flag, status bit 5, high when no unread set remains.
// RULE8: Unread count rises per period, falls per read; shows 11111 when full.
// RULE9: Routing bits 2 and 1 gate watermark and overrun onto pin one, ORed.
// RULE10: Bypass clears buffer, freezes outputs, status reads 0x20; outputs follow live data while the enable bit is clear.
// RULE11: Enable bit alone collects nothing; outputs stay frozen.
// RULE12: Fill-once stores 32 sets then stops; status reads 0xDF.
// RULE13: Host selects bypass before restarting fill-once.
// RULE14: Streaming wraps and overwrites oldest when full; bypass stops it.
// RULE15: A read moves output registers out and loads the next oldest set.
// RULE16: Full readout is 32 sets of six bytes, oldest first.
// RULE17: Host should read all 192 bytes within one sample period on overrun.
// RULE18: Slow reads let new samples overwrite unread slots, flagged by overrun.
// RULE19: Stream-to-fill acts as streaming, stops only while trigger and overrun high.
// RULE20: Config bit 5 selects generator one (0) or two (1) as trigger.
// RULE21: Reset clears enable, selects bypass, zero watermark, no pin routing.
// RULE22: One six-byte set per slot, written at each sample period end.
module asf_sample_fifo
    import asf_pkg::*;
(
    // Clock and reset
    input  wire logic                 ref_clk_i,
    input  wire logic                 resetn_i,
    // Register port
    input  wire logic                 reg_wr_i,
    input  wire logic [7:0]           reg_addr_i,
    input  wire logic [7:0]           reg_wdata_i,
    output logic      [7:0]           reg_rdata_o,
    // Sample source, sample clock marks each period end
    input  wire logic                 sample_clk_i,
    input  wire logic [ASF_SET_W-1:0] sample_data_i,
    // Motion generator active flags
    input  wire logic                 gen1_active_i,
    input  wire logic                 gen2_active_i,
    // Output register read request
    input  wire logic                 set_read_i,
    output logic                      set_read_ready_o,
    output logic      [ASF_SET_W-1:0] out_set_o,
    // Serial output buffer side
    output logic                      ser_valid_o,
    input  wire logic                 ser_ready_i,
    output logic      [ASF_SET_W-1:0] ser_data_o,
    // Interrupt pin one
    output logic                      interrupt_pin_one_o
);
    import asf_pkg::*;

    // Register decode, used only by register reads
    function automatic logic [7:0] reg_view(input logic [7:0] addr, input logic [7:0] route,
                                            input logic [7:0] en, input logic [7:0] cfg,
                                            input logic [7:0] stat);
        logic [7:0] v;
        v = ASF_BYTE_ZERO;
        case (addr)
            ASF_ADDR_ROUTE:  v = route;
            ASF_ADDR_ENABLE: v = en;
            ASF_ADDR_CFG:    v = cfg;
            ASF_ADDR_STATUS: v = stat;
            default:         v = ASF_BYTE_ZERO;
        endcase
        return v;
    endfunction

    logic                 watermark_to_pin_one_q;
    logic                 overrun_to_pin_one_q;
    logic                 buffer_enable_q;
    asf_mode_t            buffer_mode_select_q;
    logic                 trigger_source_select_q;
    logic [4:0]           watermark_level_q;
    logic                 sclk_s1_q;
    logic                 sclk_s2_q;
    logic                 sclk_s3_q;
    logic [ASF_SET_W-1:0] sdat_s1_q;
    logic [ASF_SET_W-1:0] sdat_s2_q;
    logic [ASF_SET_W-1:0] live_q;
    logic [ASF_PTR_W-1:0] wr_ptr_q;
    logic [ASF_PTR_W-1:0] rd_ptr_q;
    logic [ASF_PTR_W-1:0] rd_ptr_d;
    logic [ASF_CNT_W-1:0] count_q;
    logic [ASF_CNT_W-1:0] count_d;
    logic                 fill_done_q;
    logic [ASF_SET_W-1:0] mem_rdata;
    logic [1:0]           skid_cnt_q;
    logic [1:0]           skid_cnt_d;
    logic [ASF_SET_W-1:0] skid1_q;
    logic                 odr_tick;
    logic                 active;
    logic                 full;
    logic                 trig;
    logic                 collect;
    logic                 wr_en;
    logic                 read_acc;
    logic                 advance;
    logic                 ser_pop;
    logic                 watermark_flag;
    logic                 overrun_flag;
    logic                 empty_flag;
    logic [4:0]           unread_sample_count;
    logic [7:0]           status;
    logic [7:0]           route_byte;
    logic [7:0]           enable_byte;
    logic [7:0]           cfg_byte;

    // Control registers; reset leaves buffer off and in bypass
    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            watermark_to_pin_one_q  <= 1'b0; // RULE21
            overrun_to_pin_one_q    <= 1'b0;
            buffer_enable_q         <= 1'b0;
            buffer_mode_select_q    <= ASF_BYPASS;
            trigger_source_select_q <= 1'b0;
            watermark_level_q       <= ASF_FTH_RST;
        end else if (reg_wr_i) begin
            case (reg_addr_i)
                ASF_ADDR_ROUTE: begin
                    watermark_to_pin_one_q <= reg_wdata_i[ASF_RT_WTM_BIT];
                    overrun_to_pin_one_q   <= reg_wdata_i[ASF_RT_OVR_BIT];
                end
                ASF_ADDR_ENABLE: begin
                    buffer_enable_q <= reg_wdata_i[ASF_EN_BIT];
                end
                ASF_ADDR_CFG: begin
                    buffer_mode_select_q <=
                        asf_mode_t'(reg_wdata_i[ASF_CFG_MODE_HI:ASF_CFG_MODE_LO]); // RULE2
                    trigger_source_select_q <= reg_wdata_i[ASF_CFG_TRIG_BIT];
                    watermark_level_q       <= reg_wdata_i[ASF_CFG_FTH_HI:0];
                end
                default: begin
                end
            endcase
        end
    end

    // Sample clock and data cross in through two flops each
    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            sclk_s1_q <= 1'b0;
            sclk_s2_q <= 1'b0;
            sclk_s3_q <= 1'b0;
            sdat_s1_q <= ASF_SET_ZERO;
            sdat_s2_q <= ASF_SET_ZERO;
        end else begin
            sclk_s1_q <= sample_clk_i;
            sclk_s2_q <= sclk_s1_q;
            sclk_s3_q <= sclk_s2_q;
            sdat_s1_q <= sample_data_i;
            sdat_s2_q <= sdat_s1_q;
        end
    end

    // Period end is the rising edge of the settled sample clock
    assign odr_tick = sclk_s2_q && !sclk_s3_q;

    // Mode and trigger decode
    assign active  = buffer_enable_q && (buffer_mode_select_q != ASF_BYPASS); // RULE11
    assign full    = (count_q == ASF_CNT_FULL);
    assign trig    = trigger_source_select_q ? gen2_active_i : gen1_active_i; // RULE3 RULE20
    always_comb begin
        collect = 1'b0;
        case (buffer_mode_select_q)
            ASF_FILL_ONCE:      collect = !full && !fill_done_q; // RULE12
            ASF_STREAM:         collect = 1'b1; // RULE14
            ASF_STREAM_TO_FILL: collect = !(trig && full); // RULE19
            default:            collect = 1'b0;
        endcase
    end
    assign wr_en    = odr_tick && active && collect; // RULE22
    assign read_acc = set_read_i && set_read_ready_o;
    assign advance  = read_acc && active && (count_q != ASF_CNT_ZERO); // RULE15

    // Oldest pointer also moves when a write overruns a full buffer
    always_comb begin
        rd_ptr_d = rd_ptr_q;
        if (!active) begin
            rd_ptr_d = ASF_PTR_ZERO;
        end else if (advance || (wr_en && full)) begin
            rd_ptr_d = rd_ptr_q + ASF_PTR_ONE; // RULE6 RULE18
        end
    end

    // Unread count; a write into a full buffer replaces, never adds
    always_comb begin
        count_d = count_q;
        if (!active) begin
            count_d = ASF_CNT_ZERO; // RULE10
        end else if (wr_en && !advance && !full) begin
            count_d = count_q + ASF_CNT_ONE; // RULE8
        end else if (advance && !wr_en) begin
            count_d = count_q - ASF_CNT_ONE; // RULE8
        end
    end

    // Pointers, count and fill-once latch
    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            wr_ptr_q    <= ASF_PTR_ZERO;
            rd_ptr_q    <= ASF_PTR_ZERO;
            count_q     <= ASF_CNT_ZERO;
            fill_done_q <= 1'b0;
        end else begin
            rd_ptr_q <= rd_ptr_d;
            count_q  <= count_d;
            if (!active) begin
                wr_ptr_q <= ASF_PTR_ZERO; // RULE10
            end else if (wr_en) begin
                wr_ptr_q <= wr_ptr_q + ASF_PTR_ONE; // RULE14
            end
            // Only bypass or a cleared enable bit releases a finished fill, reads do not
            if (!active) begin
                fill_done_q <= 1'b0; // RULE13
            end else if (buffer_mode_select_q == ASF_FILL_ONCE && full) begin
                fill_done_q <= 1'b1; // RULE12
            end
        end
    end

    // Slot storage; read address is the pointer's next value, one cycle ahead of it
    asf_slot_mem u_slots (
        .clk_i   (ref_clk_i),
        .we_i    (wr_en),
        .waddr_i (wr_ptr_q),
        .wdata_i (sdat_s2_q),
        .raddr_i (rd_ptr_d),
        .rdata_o (mem_rdata)
    );

    // Live value and output registers
    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            live_q    <= ASF_SET_ZERO;
            out_set_o <= ASF_SET_ZERO;
        end else begin
            if (odr_tick) begin
                live_q <= sdat_s2_q;
            end
            if (!buffer_enable_q) begin
                out_set_o <= live_q;
            end else if (active && count_q != ASF_CNT_ZERO) begin
                out_set_o <= mem_rdata; // RULE1 RULE16
            end
        end
    end

    // Status fields; bypass yields 0x20 since the count is zero
    assign overrun_flag        = full; // RULE6
    assign empty_flag          = (count_q == ASF_CNT_ZERO); // RULE7
    assign watermark_flag      = ({1'b0, unread_sample_count} > {1'b0, watermark_level_q}) || full;
    assign unread_sample_count = full ? ASF_FSS_SAT : count_q[4:0]; // RULE8
    assign status = {watermark_flag, overrun_flag, empty_flag, unread_sample_count}; // RULE4 RULE5
    assign route_byte  = {5'h00, watermark_to_pin_one_q, overrun_to_pin_one_q, 1'b0};
    assign enable_byte = {1'b0, buffer_enable_q, 6'h00};
    assign cfg_byte    = {buffer_mode_select_q, trigger_source_select_q, watermark_level_q};

    // Read data and interrupt pin, both registered
    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            reg_rdata_o         <= ASF_BYTE_ZERO;
            interrupt_pin_one_o <= 1'b0;
        end else begin
            reg_rdata_o <= reg_view(reg_addr_i, route_byte, enable_byte, cfg_byte, status);
            interrupt_pin_one_o <= (watermark_flag && watermark_to_pin_one_q)
                                || (overrun_flag && overrun_to_pin_one_q); // RULE9
        end
    end

    // Two-entry buffer toward the serial side; ready stalls reads
    assign ser_pop = ser_valid_o && ser_ready_i;
    always_comb begin
        skid_cnt_d = skid_cnt_q;
        if (read_acc && !ser_pop) begin
            skid_cnt_d = skid_cnt_q + ASF_SKID_ONE;
        end else if (!read_acc && ser_pop) begin
            skid_cnt_d = skid_cnt_q - ASF_SKID_ONE;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            skid_cnt_q       <= ASF_SKID_ZERO;
            skid1_q          <= ASF_SET_ZERO;
            ser_data_o       <= ASF_SET_ZERO;
            ser_valid_o      <= 1'b0;
            set_read_ready_o <= 1'b0;
        end else begin
            skid_cnt_q       <= skid_cnt_d;
            ser_valid_o      <= (skid_cnt_d != ASF_SKID_ZERO);
            set_read_ready_o <= (skid_cnt_d != ASF_SKID_FULL);
            if (ser_pop) begin
                if (skid_cnt_q == ASF_SKID_FULL) begin
                    ser_data_o <= skid1_q;
                    if (read_acc) begin
                        skid1_q <= out_set_o;
                    end
                end else if (read_acc) begin
                    ser_data_o <= out_set_o; // RULE15
                end
            end else if (read_acc) begin
                if (skid_cnt_q == ASF_SKID_ZERO) begin
                    ser_data_o <= out_set_o;
                end else begin
                    skid1_q <= out_set_o;
                end
            end
        end
    end

    // Checks
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!resetn_i);

    sequence s_full_tick;
        active && full && wr_en && !advance;
    endsequence

    bypass_status_a: assert property (!active |=> status == ASF_STATUS_BYPASS) // RULE10
        else $error("status not 0x20 outside collecting modes");
    overrun_wrap_a: assert property (s_full_tick |=>
            full && rd_ptr_q == $past(rd_ptr_q) + ASF_PTR_ONE) // RULE6
        else $error("full write did not replace oldest set");
    fill_stop_a: assert property (fill_done_q && buffer_mode_select_q == ASF_FILL_ONCE
            && active |=> $stable(wr_ptr_q)) // RULE12
        else $error("fill-once kept collecting after filling");
    fill_status_a: assert property (active && buffer_mode_select_q == ASF_FILL_ONCE && full
            && !advance |=> status == ASF_STATUS_FULL) // RULE12
        else $error("full fill-once status not 0xDF");
    count_up_a: assert property (active && wr_en && !advance && !full
            |=> count_q == $past(count_q) + ASF_CNT_ONE) // RULE8
        else $error("count did not rise on sample write");
    count_down_a: assert property (advance && !wr_en
            |=> count_q == $past(count_q) - ASF_CNT_ONE ##0 !full) // RULE6
        else $error("count did not fall on set read");
    trigger_hold_a: assert property (active && buffer_mode_select_q == ASF_STREAM_TO_FILL
            && trig && full && odr_tick |=> $stable(wr_ptr_q)) // RULE19
        else $error("stream-to-fill wrote while triggered and full");
    pin_route_a: assert property (##1 interrupt_pin_one_o ==
            (($past(watermark_flag) && $past(watermark_to_pin_one_q))
            || ($past(overrun_flag) && $past(overrun_to_pin_one_q)))) // RULE9
        else $error("pin one does not follow routed flags");
    wtm_level_a: assert property (empty_flag |-> !watermark_flag && !overrun_flag) // RULE4 RULE7
        else $error("flags set while buffer empty");
    skid_hold_a: assert property (ser_valid_o && !ser_ready_i |=> ser_valid_o
            && $stable(ser_data_o)) // RULE15
        else $error("serial word changed under stall");
endmodule
`default_nettype wire

// ### src/asf_pkg.sv
package asf_pkg;

    // Register map
    localparam logic [7:0] ASF_ADDR_ROUTE = 8'h22;
    localparam logic [7:0] ASF_ADDR_ENABLE = 8'h24;
    localparam logic [7:0] ASF_ADDR_CFG = 8'h2E;
    localparam logic [7:0] ASF_ADDR_STATUS = 8'h2F;

    // Field positions
    localparam int ASF_EN_BIT = 6;
    localparam int ASF_RT_WTM_BIT = 2;
    localparam int ASF_RT_OVR_BIT = 1;
    localparam int ASF_CFG_MODE_HI = 7;
    localparam int ASF_CFG_MODE_LO = 6;
    localparam int ASF_CFG_TRIG_BIT = 5;
    localparam int ASF_CFG_FTH_HI = 4;

    // Reset values
    localparam logic [1:0] ASF_MODE_RST = 2'h0;
    localparam logic [4:0] ASF_FTH_RST = 5'h00;
    localparam logic [7:0] ASF_BYTE_ZERO = 8'h00;

    // Buffer geometry
    localparam int ASF_SET_W = 48;
    localparam int ASF_PTR_W = 5;
    localparam int ASF_CNT_W = 6;
    localparam int ASF_DEPTH = 32;
    localparam logic [ASF_PTR_W-1:0] ASF_PTR_ZERO = 5'h00;
    localparam logic [ASF_PTR_W-1:0] ASF_PTR_ONE = 5'h01;
    localparam logic [ASF_CNT_W-1:0] ASF_CNT_ZERO = 6'h00;
    localparam logic [ASF_CNT_W-1:0] ASF_CNT_ONE = 6'h01;
    localparam logic [ASF_CNT_W-1:0] ASF_CNT_FULL = 6'h20;
    localparam logic [4:0] ASF_FSS_SAT = 5'h1F;
    localparam logic [ASF_SET_W-1:0] ASF_SET_ZERO = 48'h0000_0000_0000;
    localparam logic [7:0] ASF_STATUS_BYPASS = 8'h20;
    localparam logic [7:0] ASF_STATUS_FULL = 8'hDF;

    // Output skid buffer
    localparam logic [1:0] ASF_SKID_ZERO = 2'h0;
    localparam logic [1:0] ASF_SKID_ONE = 2'h1;
    localparam logic [1:0] ASF_SKID_FULL = 2'h2;

    // Buffer modes
    typedef enum logic [1:0] {
        ASF_BYPASS,
        ASF_FILL_ONCE,
        ASF_STREAM,
        ASF_STREAM_TO_FILL
    } asf_mode_t;

endpackage

// ### src/asf_slot_mem.sv
`timescale 1ns/1ns
`default_nettype none
// Sample set storage, registered read, write-first on address match
module asf_slot_mem
    import asf_pkg::*;
(
    // Clock
    input  wire logic                 clk_i,
    // Write side
    input  wire logic                 we_i,
    input  wire logic [ASF_PTR_W-1:0] waddr_i,
    input  wire logic [ASF_SET_W-1:0] wdata_i,
    // Read side
    input  wire logic [ASF_PTR_W-1:0] raddr_i,
    output logic      [ASF_SET_W-1:0] rdata_o
);
    logic [ASF_SET_W-1:0] mem_q [ASF_DEPTH];

    // Storage array, no reset needed for data
    always_ff @(posedge clk_i) begin
        if (we_i) begin
            mem_q[waddr_i] <= wdata_i;
        end
    end

    // Write-first so a set written to the slot under the read address, as into an empty buffer, reads fresh
    always_ff @(posedge clk_i) begin
        if (we_i && (waddr_i == raddr_i)) begin
            rdata_o <= wdata_i;
        end else begin
            rdata_o <= mem_q[raddr_i];
        end
    end
endmodule
`default_nettype wire

// ### bench/asf_far_model.sv
`timescale 1ns/1ns
`default_nettype none
// Far side: sample source on a slow clock of its own, and the serial word consumer
module asf_far_model
    import asf_pkg::*;
(
    // Clock
    input  wire logic                 clk_i,
    // Sample link
    output logic                      sample_clk_o,
    output logic      [ASF_SET_W-1:0] sample_data_o,
    // Serial output buffer side
    input  wire logic                 ser_valid_i,
    input  wire logic [ASF_SET_W-1:0] ser_data_i,
    input  wire logic                 stall_i,
    output logic                      ser_ready_o
);
    int unsigned          n_sent = 0;
    logic [ASF_SET_W-1:0] rx_q[$];

    // Link clock stands low between bursts
    initial begin
        sample_clk_o = 1'b0;
        sample_data_o = ASF_SET_ZERO;
    end

    // One 160 ns period per set; data inverted once its hold has run out
    task automatic send(input int n);
        repeat (n) begin
            #40 sample_data_o = {16'hA5C3, 32'(n_sent)};
            #40 sample_clk_o = 1'b1;
            n_sent++;
            #40 sample_data_o = ~sample_data_o;
            #40 sample_clk_o = 1'b0;
        end
        #80;
    endtask

    // Consumer may stall, so the skid buffer has to hold words back
    assign ser_ready_o = !stall_i;

    // Collect every word handed over
    always @(posedge clk_i) begin
        if (ser_valid_i && ser_ready_o) begin
            rx_q.push_back(ser_data_i);
        end
    end
endmodule
`default_nettype wire

// ### bench/testbench.sv
`timescale 1ns/1ns
`default_nettype none
// Self-checking bench for the sample buffer
module testbench;
    import asf_pkg::*;
    logic                 ref_clk_i, resetn_i, reg_wr_i, sample_clk_i, gen1_active_i;
    logic                 gen2_active_i, set_read_i, set_read_ready_o, ser_valid_o;
    logic                 ser_ready_i, interrupt_pin_one_o, stall;
    logic [7:0]           reg_addr_i, reg_wdata_i, reg_rdata_o;
    logic [ASF_SET_W-1:0] sample_data_i, out_set_o, ser_data_o;
    int                   num_errors = 0;
    int                   n_compared = 0;
    int                   base;

    asf_sample_fifo dut_u (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .reg_wr_i(reg_wr_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
        .sample_clk_i(sample_clk_i), .sample_data_i(sample_data_i),
        .gen1_active_i(gen1_active_i), .gen2_active_i(gen2_active_i), .set_read_i(set_read_i),
        .set_read_ready_o(set_read_ready_o), .out_set_o(out_set_o), .ser_valid_o(ser_valid_o),
        .ser_ready_i(ser_ready_i), .ser_data_o(ser_data_o),
        .interrupt_pin_one_o(interrupt_pin_one_o));
    asf_far_model far_u (.clk_i(ref_clk_i), .sample_clk_o(sample_clk_i),
        .sample_data_o(sample_data_i), .ser_valid_i(ser_valid_o), .ser_data_i(ser_data_o),
        .stall_i(stall), .ser_ready_o(ser_ready_i));

    // 250 MHz clock
    initial begin
        ref_clk_i = 1'b0;
        forever #2 ref_clk_i = ~ref_clk_i;
    end

    function automatic logic [ASF_SET_W-1:0] exp_set(input int i);
        return {16'hA5C3, 32'(i)};
    endfunction

    task automatic results();
        $display("Compared %0d, mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Comparison bookkeeping shared by all compare tasks
    task automatic tally(input bit ok, input string msg);
        n_compared++;
        if (!ok) begin
            num_errors++;
            $display("CHECK FAILED at %0t: %s", $time, msg);
        end
    endtask
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp, input string msg);
        tally(got === exp, msg);
    endtask
    task automatic chk_set(input logic [ASF_SET_W-1:0] got, input logic [ASF_SET_W-1:0] exp,
                           input string msg);
        tally(got === exp, msg);
    endtask
    task automatic chk_bit(input logic got, input logic exp, input string msg);
        tally(got === exp, msg);
    endtask

    // Register port: one-cycle write strobe, read data one cycle after address
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk_i);
        #1 {reg_wr_i, reg_addr_i, reg_wdata_i} = {1'b1, a, d};
        @(posedge ref_clk_i);
        #1 reg_wr_i = 1'b0;
    endtask
    task automatic chk_reg(input logic [7:0] a, input logic [7:0] e, input string msg);
        @(posedge ref_clk_i);
        #1 reg_addr_i = a;
        repeat (2) @(posedge ref_clk_i);
        #1 chk_byte(reg_rdata_o, e, msg);
    endtask
    task automatic chk_pin(input logic e);
        repeat (2) @(posedge ref_clk_i);
        #1 chk_bit(interrupt_pin_one_o, e, "interrupt pin one");
    endtask

    // One set read, raised only once ready has settled high after an edge
    task automatic rd_set();
        int i = 0;
        @(posedge ref_clk_i);
        #1;
        while (set_read_ready_o !== 1'b1 && i < 50) begin
            @(posedge ref_clk_i);
            #1 i++;
        end
        if (i == 50) begin
            tally(1'b0, "read ready timeout");
            results();
        end
        set_read_i = 1'b1;
        @(posedge ref_clk_i);
        #1 set_read_i = 1'b0;
    endtask

    // Consumer stalls for the first reads so the two-entry buffer fills up
    task automatic read_sets(input int n, input int first);
        far_u.rx_q.delete();
        stall = 1'b1;
        for (int i = 0; i < n; i++) begin
            if (i == 2) begin
                repeat (2) @(posedge ref_clk_i);
                #1 chk_bit(set_read_ready_o, 1'b0, "ready while buffer full");
                stall = 1'b0;
            end
            rd_set();
        end
        repeat (4) @(posedge ref_clk_i);
        #1 chk_byte(8'(far_u.rx_q.size()), 8'(n), "words read out");
        foreach (far_u.rx_q[i]) chk_set(far_u.rx_q[i], exp_set(first + i), "readout order");
    endtask

    task automatic t_reset();
        chk_reg(ASF_ADDR_ROUTE, 8'h00, "route reset");
        chk_reg(ASF_ADDR_ENABLE, 8'h00, "enable reset");
        chk_reg(ASF_ADDR_CFG, 8'h00, "config reset");
        chk_reg(ASF_ADDR_STATUS, 8'h20, "status reset");
        chk_reg(8'h30, 8'h00, "unmapped read");
        $display("test reset done");
    endtask

    task automatic t_fill();
        wr(ASF_ADDR_ENABLE, 8'h40);
        far_u.send(3);
        chk_reg(ASF_ADDR_STATUS, 8'h20, "enabled, not collecting");
        wr(ASF_ADDR_ROUTE, 8'h04);
        wr(ASF_ADDR_CFG, 8'h4F);
        base = far_u.n_sent;
        far_u.send(15);
        chk_reg(ASF_ADDR_STATUS, 8'h0F, "count at level");
        chk_pin(1'b0);
        far_u.send(1);
        chk_reg(ASF_ADDR_STATUS, 8'h90, "count above level");
        chk_pin(1'b1);
        far_u.send(18);
        chk_reg(ASF_ADDR_STATUS, 8'hDF, "fill-once full");
        chk_set(out_set_o, exp_set(base), "oldest in output");
        wr(ASF_ADDR_ROUTE, 8'h02);
        chk_pin(1'b1);
        stall = 1'b0;
        rd_set();
        chk_reg(ASF_ADDR_STATUS, 8'h9F, "overrun cleared by read");
        read_sets(31, base + 1);
        chk_reg(ASF_ADDR_STATUS, 8'h20, "empty after readout");
        wr(ASF_ADDR_ROUTE, 8'h06);
        chk_pin(1'b0);
        wr(ASF_ADDR_CFG, 8'h0F);
        $display("test fill-once done");
    endtask

    task automatic t_stream();
        wr(ASF_ADDR_CFG, 8'h8F);
        base = far_u.n_sent;
        far_u.send(34);
        chk_reg(ASF_ADDR_STATUS, 8'hDF, "stream full");
        chk_set(out_set_o, exp_set(base + 2), "oldest overwritten");
        read_sets(32, base + 2);
        chk_reg(ASF_ADDR_STATUS, 8'h20, "stream drained");
        wr(ASF_ADDR_CFG, 8'h0F);
        chk_reg(ASF_ADDR_STATUS, 8'h20, "bypass status");
        $display("test stream done");
    endtask

    task automatic t_trigger();
        gen1_active_i = 1'b1;
        wr(ASF_ADDR_CFG, 8'hEF);
        base = far_u.n_sent;
        far_u.send(34);
        chk_set(out_set_o, exp_set(base + 2), "other generator ignored");
        gen2_active_i = 1'b1;
        far_u.send(2);
        chk_set(out_set_o, exp_set(base + 2), "stopped on trigger");
        chk_reg(ASF_ADDR_STATUS, 8'hDF, "held full");
        gen2_active_i = 1'b0;
        far_u.send(1);
        chk_set(out_set_o, exp_set(base + 3), "streams again on low");
        wr(ASF_ADDR_CFG, 8'hCF);
        far_u.send(1);
        chk_set(out_set_o, exp_set(base + 3), "generator one selected");
        wr(ASF_ADDR_CFG, 8'h00);
        chk_reg(ASF_ADDR_STATUS, 8'h20, "bypass clears");
        $display("test trigger done");
    endtask

    // Main sequence
    initial begin
        {resetn_i, reg_wr_i, set_read_i, gen1_active_i, gen2_active_i, stall} = 6'h00;
        reg_addr_i = 8'h00;
        reg_wdata_i = 8'h00;
        repeat (8) @(posedge ref_clk_i);
        #1 resetn_i = 1'b1;
        repeat (2) @(posedge ref_clk_i);
        t_reset();
        t_fill();
        t_stream();
        t_trigger();
        results();
    end
endmodule
`default_nettype wire
